/* File: design/watchdog_mode_and_control.sv */
// watchdog mode and control block with apb register access
// assumes: pclk 25 MHz, light_idle_state is a pin, async level
// Operation
// - two-bit period field picks 2^15, 2^17, 2^19 or 2^21 clocks.
// - mode bit 2 clear stops count in light idle; set keeps counting.
// - mode bit 1 set routes overflow onto the reset pin output.
// - writing B1 to command register disables watchdog; no RMW.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module watchdog_mode_and_control #(
   parameter logic [7:0] CLEAR_CODE = wdt_pkg::CLEAR_CODE_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic light_idle_state,
   output logic reset_pin_out,
   output logic wdt_irq
);
   import wdt_pkg::*;
   initial begin
      if (CLEAR_CODE == DISABLE_CODE)
         $error("clear code must differ from disable code");
   end
   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   logic idle_s1_r, idle_s2_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_s1_r <= 1'b0;
         idle_s2_r <= 1'b0;
      end else begin
         idle_s1_r <= light_idle_state;
         idle_s2_r <= idle_s1_r;
      end
   end
   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic acc, wr, rd, hit_mode, hit_cmd, hit_stat, hit_mask, hit;
   always_comb begin
      acc = psel && penable;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      hit_mode = paddr[13:0] == MODE_ADDR && paddr[31:14] == '0;
      hit_cmd = paddr[13:0] == CMD_ADDR && paddr[31:14] == '0;
      hit_stat = paddr[13:0] == STAT_ADDR && paddr[31:14] == '0;
      hit_mask = paddr[13:0] == MASK_ADDR && paddr[31:14] == '0;
      hit = hit_mode || hit_cmd || hit_stat || hit_mask;
   end
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] mode_r, mode_nxt;
   logic stat_r, stat_nxt, mask_r, mask_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt, rst_nxt, irq_nxt;
   logic run, clear, ovf;
   always_comb begin
      mode_nxt = mode_r;
      mask_nxt = mask_r;
      clear = 1'b0;
      if (wr && hit_mode)
         mode_nxt = (pwdata[7:0] & MODE_WMASK) | (mode_r & ~MODE_WMASK);
      if (wr && hit_cmd && pwdata[7:0] == DISABLE_CODE)
         mode_nxt[ENABLE_POS] = 1'b0;
      if (wr && hit_cmd && pwdata[7:0] == CLEAR_CODE)
         clear = 1'b1;
      if (wr && hit_mask)
         mask_nxt = pwdata[STAT_OVF_POS];
      run = mode_r[ENABLE_POS] &&
            (!idle_s2_r || mode_r[IDLE_RUN_POS]);
      // set wins over write-one-to-clear
      stat_nxt = stat_r;
      if (wr && hit_stat && pwdata[STAT_OVF_POS])
         stat_nxt = 1'b0;
      if (ovf)
         stat_nxt = 1'b1;
      rst_nxt = ovf && mode_r[RST_CONN_POS];
      irq_nxt = stat_nxt && mask_nxt;
      // access phase lasts one cycle: pready is decoded in setup, high in access
      pready_nxt = psel && !penable;
      pslverr_nxt = psel && !penable && !hit;
      prdata_nxt = '0;
      if (psel && !penable && !pwrite) begin
         if (hit_mode)
            prdata_nxt = {24'h000000, mode_r};
         else if (hit_stat)
            prdata_nxt = {31'h0, stat_r};
         else if (hit_mask)
            prdata_nxt = {31'h0, mask_r};
      end
      if (rd)
         prdata_nxt = '0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_RESET;
         stat_r <= 1'b0;
         mask_r <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         reset_pin_out <= 1'b0;
         wdt_irq <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         reset_pin_out <= rst_nxt;
         wdt_irq <= irq_nxt;
      end
   end
   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   wdt_counter #(.CNT_W(CNT_W)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .clear(clear),
      .period_sel({mode_r[PSEL_HI_POS], mode_r[PSEL_LO_POS]}),
      .overflow(ovf)
   );
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] gap_r;
   logic [CNT_W-1:0] need;
   always_comb begin
      need = CNT_W'((64'd1 << (PERIOD_EXP0 + PERIOD_EXP_STEP *
             int'({mode_r[PSEL_HI_POS], mode_r[PSEL_LO_POS]}))) - 64'd1);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r <= '0;
      end else if (ovf || clear) begin
         gap_r <= '0;
      end else if (run) begin
         gap_r <= gap_r + CNT_W'(1);
      end
   end
   property p_period;
      @(posedge pclk) disable iff (!presetn)
      ovf |-> gap_r == need;
   endproperty
   a_period: assert property (p_period)
      else $error("overflow at wrong count");
   property p_idle_stop;
      @(posedge pclk) disable iff (!presetn)
      idle_s2_r && !mode_r[IDLE_RUN_POS] |-> !run && !ovf;
   endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("count runs in light idle");
   property p_rst_conn;
      @(posedge pclk) disable iff (!presetn)
      ovf |=> reset_pin_out == $past(mode_r[RST_CONN_POS]);
   endproperty
   a_rst_conn: assert property (p_rst_conn)
      else $error("reset pin does not follow overflow");
   property p_disable;
      @(posedge pclk) disable iff (!presetn)
      wr && hit_cmd && pwdata[7:0] == DISABLE_CODE |=>
         !mode_r[ENABLE_POS] ##1 !ovf;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable code ignored");
   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      clear |=> !ovf [*8];
   endproperty
   a_clear: assert property (p_clear)
      else $error("overflow soon after clear");
   // flag, pin, counter and bus checks
   property p_ovf_status;
      @(posedge pclk) disable iff (!presetn)
      ovf |=> stat_r;
   endproperty
   a_ovf_status: assert property (p_ovf_status)
      else $error("overflow did not set status");
   property p_stat_sticky;
      @(posedge pclk) disable iff (!presetn)
      stat_r && !(wr && hit_stat && pwdata[STAT_OVF_POS]) |=> stat_r;
   endproperty
   a_stat_sticky: assert property (p_stat_sticky)
      else $error("status dropped without a clear");
   property p_rst_off;
      @(posedge pclk) disable iff (!presetn)
      !ovf || !mode_r[RST_CONN_POS] |=> !reset_pin_out;
   endproperty
   a_rst_off: assert property (p_rst_off)
      else $error("reset pin pulsed while not connected");
   property p_cmd_wo;
      @(posedge pclk) disable iff (!presetn)
      rd && hit_cmd |-> prdata == 32'h00000000;
   endproperty
   a_cmd_wo: assert property (p_cmd_wo)
      else $error("command register read back nonzero");
   property p_clear_zero;
      @(posedge pclk) disable iff (!presetn)
      clear |=> u_cnt.cnt_r == '0;
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("clear code did not zero the count");
   property p_pready_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("pready held longer than one cycle");
endmodule
`default_nettype wire

/* File: design/wdt_pkg.sv */
// package: register map, field positions, reset values and periods
// assumes: 32-bit apb, one register per aligned word
package wdt_pkg;
   // printed offsets are not all multiples of four: kept as indexes
   localparam logic [11:0] MODE_IDX = 12'h300;
   localparam logic [11:0] CMD_IDX = 12'h301;
   localparam logic [11:0] STAT_IDX = 12'h302;
   localparam logic [11:0] MASK_IDX = 12'h303;
   localparam logic [13:0] MODE_ADDR = {MODE_IDX, 2'b00};
   localparam logic [13:0] CMD_ADDR = {CMD_IDX, 2'b00};
   localparam logic [13:0] STAT_ADDR = {STAT_IDX, 2'b00};
   localparam logic [13:0] MASK_ADDR = {MASK_IDX, 2'b00};
   localparam int ENABLE_POS = 7;
   localparam int PSEL_HI_POS = 6;
   localparam int PSEL_LO_POS = 5;
   localparam int IDLE_RUN_POS = 2;
   localparam int RST_CONN_POS = 1;
   localparam int BIT0_POS = 0;
   localparam logic [7:0] MODE_RESET = 8'h80;
   localparam logic [7:0] MODE_WMASK = 8'hE7;
   localparam logic [7:0] DISABLE_CODE = 8'hB1;
   localparam logic [7:0] CLEAR_CODE_DEF = 8'h4E;
   localparam int PERIOD_EXP0 = 15;
   localparam int PERIOD_EXP_STEP = 2;
   localparam int CNT_W = 22;
   localparam int STAT_OVF_POS = 0;
endpackage

/* File: design/wdt_counter.sv */
// watchdog counter: free count, clear, overflow pulse at selected length
// assumes: run and clear are from logic on pclk
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
   parameter int CNT_W = 22
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic clear,
   input wire logic [1:0] period_sel,
   output logic overflow
);
   import wdt_pkg::*;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] last;
   initial begin
      if (CNT_W < PERIOD_EXP0 + 3 * PERIOD_EXP_STEP + 1)
         $error("counter too narrow for longest period");
   end
   always_comb begin
      last = CNT_W'((64'd1 << (PERIOD_EXP0 +
             PERIOD_EXP_STEP * int'(period_sel))) - 64'd1);
      overflow = run && !clear && (cnt_r == last);
      cnt_nxt = cnt_r;
      if (clear || overflow)
         cnt_nxt = '0;
      else if (run)
         cnt_nxt = cnt_r + CNT_W'(1);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end
endmodule
`default_nettype wire

/* File: tb/watchdog_mode_and_control_bench.sv */
// bench: apb register, command and overflow checks of the watchdog block
// assumes: wdt_pkg compiled first; zero-wait apb slave on a 25 MHz pclk
`timescale 1ns/1ps
`default_nettype none
module watchdog_mode_and_control_bench;
   import wdt_pkg::*;
   localparam int P = 32768;
   localparam logic [31:0] A_MODE = {18'h0, MODE_ADDR};
   localparam logic [31:0] A_CMD = {18'h0, CMD_ADDR};
   localparam logic [31:0] A_STAT = {18'h0, STAT_ADDR};
   localparam logic [31:0] A_MASK = {18'h0, MASK_ADDR};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic light_idle_state = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, reset_pin_out, wdt_irq;
   int fail_count = 0;
   int n_compared = 0;
   always #20 pclk = ~pclk;
   watchdog_mode_and_control dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .light_idle_state(light_idle_state),
      .reset_pin_out(reset_pin_out), .wdt_irq(wdt_irq));
   // ---------------------------------------------------------------
   // report, compare and apb tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         chk(32'h0, 32'h1);
         conclude();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp,
                      input logic exp_err);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, exp_err});
   endtask
   // waits for the reset pin pulse or the irq; lo..hi cycles allowed
   task automatic wait_evt(input bit use_irq, input int lo, input int hi);
      int n;
      bit seen, rp;
      n = 0;
      seen = 0;
      rp = 0;
      while (!seen && n < hi) begin
         @(negedge pclk);
         n++;
         if (reset_pin_out === 1'b1) rp = 1;
         seen = use_irq ? (wdt_irq === 1'b1) : rp;
      end
      if (!seen) begin
         chk(32'h0, 32'h1);
         conclude();
      end
      chk({31'h0, n >= lo}, 32'h1);
      chk({31'h0, rp}, {31'h0, !use_irq});
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_MODE, 32'h80, 1'b0);
      wr(A_MODE, 32'hFF);
      rdc(A_MODE, 32'hE7, 1'b0);
      rdc(A_CMD, 32'h0, 1'b0);
      rdc(32'h0000_0C10, 32'h0, 1'b1);
      light_idle_state <= 1'b1;
      wr(A_MODE, 32'h86);
      wr(A_CMD, {24'h0, CLEAR_CODE_DEF});
      wait_evt(1'b0, P - 4, P + 12);
      chk({31'h0, wdt_irq}, 32'h0);
      rdc(A_STAT, 32'h1, 1'b0);
      wr(A_MASK, 32'h1);
      repeat (2) @(negedge pclk);
      chk({31'h0, wdt_irq}, 32'h1);
      wr(A_STAT, 32'h1);
      repeat (2) @(negedge pclk);
      chk({31'h0, wdt_irq}, 32'h0);
      wr(A_MODE, 32'h80);
      wr(A_CMD, {24'h0, CLEAR_CODE_DEF});
      repeat (10000) @(posedge pclk);
      light_idle_state <= 1'b0;
      wait_evt(1'b1, P - 4, P + 16);
      wr(A_CMD, {24'h0, DISABLE_CODE});
      rdc(A_MODE, 32'h0, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
